/* File: include/plcb_pkg.sv */
// Package: command codes, reset values and formats of the limit configuration bank
package plcb_pkg;
    // ==========================================
    // Command codes
    localparam logic [7:0] CMD_PAGE           = 8'h00;
    localparam logic [7:0] CMD_SLEW           = 8'h27;
    localparam logic [7:0] CMD_FREQ           = 8'h33;
    localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD         = 8'h35;
    localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD        = 8'h36;
    localparam logic [7:0] CMD_CS_GAIN        = 8'h38;
    localparam logic [7:0] CMD_OVF            = 8'h40;
    localparam logic [7:0] CMD_OVF_ACT        = 8'h41;
    localparam logic [7:0] CMD_OVW            = 8'h42;
    localparam logic [7:0] CMD_UVW            = 8'h43;
    localparam logic [7:0] CMD_UVF            = 8'h44;
    localparam logic [7:0] CMD_UVF_ACT        = 8'h45;
    localparam logic [7:0] CMD_OCF            = 8'h46;
    localparam logic [7:0] CMD_OCF_ACT        = 8'h47;
    localparam logic [7:0] CMD_OCW            = 8'h4A;
    localparam logic [7:0] CMD_OTF            = 8'h4F;
    localparam logic [7:0] CMD_OTF_ACT        = 8'h50;
    localparam logic [7:0] CMD_OTW            = 8'h51;
    localparam logic [7:0] CMD_UTF            = 8'h53;
    localparam logic [7:0] CMD_UTF_ACT        = 8'h54;
    localparam logic [7:0] CMD_VIN_OVF        = 8'h55;
    localparam logic [7:0] CMD_VIN_OVF_ACT    = 8'h56;
    localparam logic [7:0] CMD_VIN_UVW        = 8'h58;
    localparam logic [7:0] CMD_IIN_OCW        = 8'h5D;
    // ==========================================
    // Reset values
    localparam logic [7:0]  RST_PAGE          = 8'h00;
    localparam logic [15:0] RST_SLEW          = 16'hAA00;
    localparam logic [15:0] RST_FREQ          = 16'hFABC;
    localparam logic [15:0] RST_INPUT_TURN_ON_THRESHOLD        = 16'hCB40;
    localparam logic [15:0] RST_INPUT_TURN_OFF_THRESHOLD       = 16'hCB00;
    localparam logic [15:0] RST_CS_GAIN       = 16'hBB9A;
    localparam logic [15:0] RST_OVF           = 16'h119A;
    localparam logic [15:0] RST_OVW           = 16'h1133;
    localparam logic [15:0] RST_UVW           = 16'h0ECD;
    localparam logic [15:0] RST_UVF           = 16'h0E66;
    localparam logic [15:0] RST_OCF           = 16'hDBB8;
    localparam logic [15:0] RST_OCW           = 16'hDA80;
    localparam logic [15:0] RST_OTF           = 16'hEB20;
    localparam logic [15:0] RST_OTW           = 16'hEAA8;
    localparam logic [15:0] RST_UTF           = 16'hE580;
    localparam logic [15:0] RST_VIN_OVF       = 16'hE300;
    localparam logic [15:0] RST_VIN_UVW       = 16'hCB26;
    localparam logic [15:0] RST_IIN_OCW       = 16'hD280;
    localparam logic [7:0]  RST_ACT_STD       = 8'hB8;
    localparam logic [7:0]  RST_ACT_OC        = 8'h00;
    localparam logic [7:0]  RST_ACT_VIN_OV    = 8'h80;
    // ==========================================
    // Exponent-mantissa format fields
    localparam int EM_EXP_MSB = 15;
    localparam int EM_EXP_LSB = 11;
    localparam int EM_MAN_MSB = 10;
    localparam int EM_MAN_LSB = 0;
    // Fixed output exponent is two to the minus twelve
    localparam int FIX_OUT_FRAC_BITS = 12;
    // Paged slot indices
    localparam int PG_SLEW = 0;
    localparam int PG_GAIN = 1;
    localparam int PG_OVF  = 2;
    localparam int PG_OVW  = 3;
    localparam int PG_UVW  = 4;
    localparam int PG_UVF  = 5;
    localparam int PG_OCF  = 6;
    localparam int PG_OCW  = 7;
    localparam int PG_OTF  = 8;
    localparam int PG_OTW  = 9;
    localparam int PG_UTF  = 10;
    localparam int PG_NUM  = 11;
    localparam int PA_OV   = 0;
    localparam int PA_UV   = 1;
    localparam int PA_OC   = 2;
    localparam int PA_OT   = 3;
    localparam int PA_UT   = 4;
    localparam int PA_VIN  = 5;
    localparam int PA_NUM  = 6;
    // Bus access kinds
    typedef enum logic [2:0] {
        PLCB_IDLE  = 3'b001,
        PLCB_WRITE = 3'b010,
        PLCB_READ  = 3'b100
    } plcb_acc_t;
endpackage

/* File: hw/plcb_bank.sv */
// Paged and shared limit configuration bank reached by command code
`timescale 1ns/1ps
// Contract
// - Paged 16-bit slew rate at 0x27, reset 0xAA00, read/write.
// - Shared 16-bit switching frequency at 0x33, reset 0xFABC.
// - Shared turn-on threshold 0x35, reset 0xCB40; conversion starts when input reaches it.
// - Shared turn-off threshold 0x36, reset 0xCB00; conversion stops at or below it.
// - Paged current sense gain 0x38, reset 0xBB9A, presented per channel on sense_gain_o.
// - Paged output overvoltage fault threshold 0x40, reset 0x119A.
// - Paged 8-bit overvoltage action 0x41, reset 0xB8, applied on fault.
// - Paged output overvoltage warning threshold 0x42, reset 0x1133.
// - Paged output undervoltage warning threshold 0x43, reset 0x0ECD.
// - Paged output undervoltage fault threshold 0x44, reset 0x0E66.
// - Paged undervoltage action 0x45, reset 0xB8.
// - Paged overcurrent fault threshold 0x46, reset 0xDBB8.
// - Paged overcurrent action 0x47, reset 0x00.
// - Paged overcurrent warning threshold 0x4A, reset 0xDA80.
// - Paged overtemperature fault threshold 0x4F, reset 0xEB20.
// - Paged overtemperature action 0x50, reset 0xB8.
// - Paged overtemperature warning threshold 0x51, reset 0xEAA8.
// - Paged undertemperature fault 0x53 reset 0xE580; action 0x54 reset 0xB8.
// - Shared input overvoltage fault threshold 0x55, reset 0xE300.
// - Paged input overvoltage action 0x56, reset 0x80.
// - Shared input undervoltage warning 0x58, reset 0xCB26.
// - Shared input overcurrent warning 0x5D, reset 0xD280.
// - Exponent-mantissa: signed 11-bit mantissa times two to signed 5-bit exponent.
// - Fixed output format: unsigned 16 bits times two to minus twelve.
// - Unsupported command access raises a one-cycle comm fault pulse.
// - Page command 0x00, reset 0x00, selects channel for paged accesses.
module plcb_bank #(
    parameter int NUM_PAGES = 2
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       arst_n_i,
    input  wire logic                       cmd_wr_i,
    input  wire logic                       cmd_rd_i,
    input  wire logic [7:0]                 cmd_code_i,
    input  wire logic [15:0]                cmd_wdata_i,
    input  wire logic [15:0]                vin_meas_i,
    input  wire logic [NUM_PAGES-1:0]       ov_fault_i,
    input  wire logic [NUM_PAGES-1:0]       uv_fault_i,
    input  wire logic [NUM_PAGES-1:0]       oc_fault_i,
    input  wire logic [NUM_PAGES-1:0]       ot_fault_i,
    input  wire logic [NUM_PAGES-1:0]       ut_fault_i,
    input  wire logic                       vin_ov_fault_i,
    output logic      [15:0]                cmd_rdata_o,
    output logic                            cmd_rvalid_o,
    output logic                            comm_memory_fault_o,
    output logic      [7:0]                 page_o,
    output logic                            conv_enable_o,
    output logic      [NUM_PAGES*16-1:0]    slew_rate_o,
    output logic      [NUM_PAGES*16-1:0]    sense_gain_o,
    output logic      [15:0]                sw_freq_o,
    output logic      [NUM_PAGES*8-1:0]     fault_action_o,
    output logic      [NUM_PAGES-1:0]       fault_act_valid_o
);
    import plcb_pkg::*;

    // ==========================================
    // Storage
    logic [15:0] pg_reg   [NUM_PAGES][PG_NUM];
    logic [15:0] pg_next  [NUM_PAGES][PG_NUM];
    logic [7:0]  act_reg  [NUM_PAGES][PA_NUM];
    logic [7:0]  act_next [NUM_PAGES][PA_NUM];
    logic [7:0]  page_reg, page_next;
    logic [15:0] freq_reg, freq_next;
    logic [15:0] von_reg, von_next;
    logic [15:0] voff_reg, voff_next;
    logic [15:0] vovf_reg, vovf_next;
    logic [15:0] vuvw_reg, vuvw_next;
    logic [15:0] iocw_reg, iocw_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;
    logic        cml_reg, cml_next;
    logic        conv_reg, conv_next;
    logic [NUM_PAGES*8-1:0] fact_reg, fact_next;
    logic [NUM_PAGES-1:0]   fval_reg, fval_next;
    plcb_acc_t   acc;
    logic        page_ok;
    logic        known;
    logic [15:0] rd_val;
    int          sel;

    // Access kind; a write wins if both strobes are raised together
    always_comb begin
        if (cmd_wr_i)      acc = PLCB_WRITE;
        else if (cmd_rd_i) acc = PLCB_READ;
        else               acc = PLCB_IDLE;
    end

    // Out-of-range page makes paged commands unsupported rather than alias a channel
    assign page_ok = (int'(page_reg) < NUM_PAGES);
    assign sel     = page_ok ? int'(page_reg) : 0;

    // ==========================================
    // Command decode and register update
    always_comb begin
        pg_next   = pg_reg;
        act_next  = act_reg;
        page_next = page_reg;
        freq_next = freq_reg;
        von_next  = von_reg;
        voff_next = voff_reg;
        vovf_next = vovf_reg;
        vuvw_next = vuvw_reg;
        iocw_next = iocw_reg;
        known     = 1'b1;
        rd_val    = 16'h0000;
        case (cmd_code_i)
            CMD_PAGE:        rd_val = {8'h00, page_reg};
            CMD_FREQ:        rd_val = freq_reg;
            CMD_INPUT_TURN_ON_THRESHOLD:      rd_val = von_reg;
            CMD_INPUT_TURN_OFF_THRESHOLD:     rd_val = voff_reg;
            CMD_VIN_OVF:     rd_val = vovf_reg;
            CMD_VIN_UVW:     rd_val = vuvw_reg;
            CMD_IIN_OCW:     rd_val = iocw_reg;
            CMD_SLEW:        rd_val = pg_reg[sel][PG_SLEW];
            CMD_CS_GAIN:     rd_val = pg_reg[sel][PG_GAIN];
            CMD_OVF:         rd_val = pg_reg[sel][PG_OVF];
            CMD_OVW:         rd_val = pg_reg[sel][PG_OVW];
            CMD_UVW:         rd_val = pg_reg[sel][PG_UVW];
            CMD_UVF:         rd_val = pg_reg[sel][PG_UVF];
            CMD_OCF:         rd_val = pg_reg[sel][PG_OCF];
            CMD_OCW:         rd_val = pg_reg[sel][PG_OCW];
            CMD_OTF:         rd_val = pg_reg[sel][PG_OTF];
            CMD_OTW:         rd_val = pg_reg[sel][PG_OTW];
            CMD_UTF:         rd_val = pg_reg[sel][PG_UTF];
            CMD_OVF_ACT:     rd_val = {8'h00, act_reg[sel][PA_OV]};
            CMD_UVF_ACT:     rd_val = {8'h00, act_reg[sel][PA_UV]};
            CMD_OCF_ACT:     rd_val = {8'h00, act_reg[sel][PA_OC]};
            CMD_OTF_ACT:     rd_val = {8'h00, act_reg[sel][PA_OT]};
            CMD_UTF_ACT:     rd_val = {8'h00, act_reg[sel][PA_UT]};
            CMD_VIN_OVF_ACT: rd_val = {8'h00, act_reg[sel][PA_VIN]};
            default:         known  = 1'b0;
        endcase
        // Paged codes are refused while the page points past the last channel
        if (!page_ok && cmd_code_i != CMD_PAGE && !(cmd_code_i inside
            {CMD_FREQ, CMD_INPUT_TURN_ON_THRESHOLD, CMD_INPUT_TURN_OFF_THRESHOLD, CMD_VIN_OVF, CMD_VIN_UVW, CMD_IIN_OCW}))
            known = 1'b0;
        if (acc == PLCB_WRITE && known) begin
            case (cmd_code_i)
                CMD_PAGE:        page_next = cmd_wdata_i[7:0];
                CMD_FREQ:        freq_next = cmd_wdata_i;
                CMD_INPUT_TURN_ON_THRESHOLD:      von_next  = cmd_wdata_i;
                CMD_INPUT_TURN_OFF_THRESHOLD:     voff_next = cmd_wdata_i;
                CMD_VIN_OVF:     vovf_next = cmd_wdata_i;
                CMD_VIN_UVW:     vuvw_next = cmd_wdata_i;
                CMD_IIN_OCW:     iocw_next = cmd_wdata_i;
                CMD_SLEW:        pg_next[sel][PG_SLEW] = cmd_wdata_i;
                CMD_CS_GAIN:     pg_next[sel][PG_GAIN] = cmd_wdata_i;
                CMD_OVF:         pg_next[sel][PG_OVF]  = cmd_wdata_i;
                CMD_OVW:         pg_next[sel][PG_OVW]  = cmd_wdata_i;
                CMD_UVW:         pg_next[sel][PG_UVW]  = cmd_wdata_i;
                CMD_UVF:         pg_next[sel][PG_UVF]  = cmd_wdata_i;
                CMD_OCF:         pg_next[sel][PG_OCF]  = cmd_wdata_i;
                CMD_OCW:         pg_next[sel][PG_OCW]  = cmd_wdata_i;
                CMD_OTF:         pg_next[sel][PG_OTF]  = cmd_wdata_i;
                CMD_OTW:         pg_next[sel][PG_OTW]  = cmd_wdata_i;
                CMD_UTF:         pg_next[sel][PG_UTF]  = cmd_wdata_i;
                CMD_OVF_ACT:     act_next[sel][PA_OV]  = cmd_wdata_i[7:0];
                CMD_UVF_ACT:     act_next[sel][PA_UV]  = cmd_wdata_i[7:0];
                CMD_OCF_ACT:     act_next[sel][PA_OC]  = cmd_wdata_i[7:0];
                CMD_OTF_ACT:     act_next[sel][PA_OT]  = cmd_wdata_i[7:0];
                CMD_UTF_ACT:     act_next[sel][PA_UT]  = cmd_wdata_i[7:0];
                CMD_VIN_OVF_ACT: act_next[sel][PA_VIN] = cmd_wdata_i[7:0];
                default:         page_next = page_reg;
            endcase
        end
    end

    // Read answer one cycle after the strobe; unknown codes read zero
    always_comb begin
        rvalid_next = (acc == PLCB_READ);
        rdata_next  = (acc == PLCB_READ && known) ? rd_val : 16'h0000;
        cml_next    = (acc != PLCB_IDLE) && !known;
    end

    // ==========================================
    // Input voltage hysteresis: compare as exponent-mantissa values
    // Mantissas are scaled to a common exponent; 64-bit room covers any shift
    function automatic logic signed [63:0] em_scaled(input logic [15:0] v);
        logic signed [4:0]  e;
        logic signed [10:0] m;
        logic signed [63:0] w;
        e = v[EM_EXP_MSB:EM_EXP_LSB];
        m = v[EM_MAN_MSB:EM_MAN_LSB];
        w = 64'(m) <<< 16;
        if (e >= 0) em_scaled = w <<< e;
        else        em_scaled = w >>> (-e);
        return em_scaled;
    endfunction

    always_comb begin
        conv_next = conv_reg;
        if (!conv_reg && em_scaled(vin_meas_i) >= em_scaled(von_reg))
            conv_next = 1'b1;
        else if (conv_reg && em_scaled(vin_meas_i) <= em_scaled(voff_reg))
            conv_next = 1'b0;
    end

    // ==========================================
    // Fault actions: each channel presents the code of the highest-priority fault
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAGES; gp++) begin : g_act
            always_comb begin
                fact_next[gp*8 +: 8] = 8'h00;
                fval_next[gp]        = 1'b1;
                if (vin_ov_fault_i)      fact_next[gp*8 +: 8] = act_reg[gp][PA_VIN];
                else if (ov_fault_i[gp]) fact_next[gp*8 +: 8] = act_reg[gp][PA_OV];
                else if (oc_fault_i[gp]) fact_next[gp*8 +: 8] = act_reg[gp][PA_OC];
                else if (uv_fault_i[gp]) fact_next[gp*8 +: 8] = act_reg[gp][PA_UV];
                else if (ot_fault_i[gp]) fact_next[gp*8 +: 8] = act_reg[gp][PA_OT];
                else if (ut_fault_i[gp]) fact_next[gp*8 +: 8] = act_reg[gp][PA_UT];
                else                     fval_next[gp]        = 1'b0;
            end
            assign slew_rate_o[gp*16 +: 16]  = pg_reg[gp][PG_SLEW];
            assign sense_gain_o[gp*16 +: 16] = pg_reg[gp][PG_GAIN];
        end
    endgenerate

    // ==========================================
    // Registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int p = 0; p < NUM_PAGES; p++) begin
                pg_reg[p][PG_SLEW]  <= RST_SLEW;
                pg_reg[p][PG_GAIN]  <= RST_CS_GAIN;
                pg_reg[p][PG_OVF]   <= RST_OVF;
                pg_reg[p][PG_OVW]   <= RST_OVW;
                pg_reg[p][PG_UVW]   <= RST_UVW;
                pg_reg[p][PG_UVF]   <= RST_UVF;
                pg_reg[p][PG_OCF]   <= RST_OCF;
                pg_reg[p][PG_OCW]   <= RST_OCW;
                pg_reg[p][PG_OTF]   <= RST_OTF;
                pg_reg[p][PG_OTW]   <= RST_OTW;
                pg_reg[p][PG_UTF]   <= RST_UTF;
                act_reg[p][PA_OV]   <= RST_ACT_STD;
                act_reg[p][PA_UV]   <= RST_ACT_STD;
                act_reg[p][PA_OC]   <= RST_ACT_OC;
                act_reg[p][PA_OT]   <= RST_ACT_STD;
                act_reg[p][PA_UT]   <= RST_ACT_STD;
                act_reg[p][PA_VIN]  <= RST_ACT_VIN_OV;
            end
            page_reg   <= RST_PAGE;
            freq_reg   <= RST_FREQ;
            von_reg    <= RST_INPUT_TURN_ON_THRESHOLD;
            voff_reg   <= RST_INPUT_TURN_OFF_THRESHOLD;
            vovf_reg   <= RST_VIN_OVF;
            vuvw_reg   <= RST_VIN_UVW;
            iocw_reg   <= RST_IIN_OCW;
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
            cml_reg    <= 1'b0;
            conv_reg   <= 1'b0;
            fact_reg   <= '0;
            fval_reg   <= '0;
        end else begin
            pg_reg     <= pg_next;
            act_reg    <= act_next;
            page_reg   <= page_next;
            freq_reg   <= freq_next;
            von_reg    <= von_next;
            voff_reg   <= voff_next;
            vovf_reg   <= vovf_next;
            vuvw_reg   <= vuvw_next;
            iocw_reg   <= iocw_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            cml_reg    <= cml_next;
            conv_reg   <= conv_next;
            fact_reg   <= fact_next;
            fval_reg   <= fval_next;
        end
    end

    assign cmd_rdata_o         = rdata_reg;
    assign cmd_rvalid_o        = rvalid_reg;
    assign comm_memory_fault_o = cml_reg;
    assign page_o              = page_reg;
    assign conv_enable_o       = conv_reg;
    assign sw_freq_o           = freq_reg;
    assign fault_action_o      = fact_reg;
    assign fault_act_valid_o   = fval_reg;

    // ==========================================
    // Assertions
    a_unknown_cmd_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (cmd_rd_i || cmd_wr_i) && !known |=> comm_memory_fault_o)
        else $error("unsupported command did not raise fault");
    a_read_answers: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        cmd_rd_i && !cmd_wr_i |=> cmd_rvalid_o)
        else $error("read gave no answer");
    a_page_readback: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        cmd_wr_i && cmd_code_i == CMD_PAGE ##1 !cmd_wr_i ##1 cmd_rd_i && !cmd_wr_i
        && cmd_code_i == CMD_PAGE |=> cmd_rdata_o == {8'h00, $past(cmd_wdata_i[7:0], 3)})
        else $error("page readback mismatch");
    a_freq_shared: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        cmd_wr_i && cmd_code_i == CMD_FREQ |=> sw_freq_o == $past(cmd_wdata_i))
        else $error("frequency write lost");
    a_slew_write: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        cmd_wr_i && cmd_code_i == CMD_SLEW && page_reg == 8'h00
        |=> slew_rate_o[15:0] == $past(cmd_wdata_i))
        else $error("slew rate write lost");
    a_conv_on: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !conv_enable_o && em_scaled(vin_meas_i) >= em_scaled(von_reg) |=> conv_enable_o)
        else $error("conversion did not start");
    a_conv_off: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        conv_enable_o && em_scaled(vin_meas_i) <= em_scaled(voff_reg) |=> !conv_enable_o)
        else $error("conversion did not stop");
    a_ov_action: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !vin_ov_fault_i && ov_fault_i[0]
        |=> fault_act_valid_o[0] && fault_action_o[7:0] == $past(act_reg[0][PA_OV]))
        else $error("overvoltage action not applied");
    c_page_write: cover property (@(posedge clk_sys_i) cmd_wr_i && cmd_code_i == CMD_PAGE);
    c_bad_cmd: cover property (@(posedge clk_sys_i) comm_memory_fault_o);
    c_conv_cycle: cover property (@(posedge clk_sys_i) conv_enable_o ##[1:50] !conv_enable_o);
endmodule // plcb_bank

/* File: test/plcb_host.sv */
// Host-side model issuing one command access at a time
`timescale 1ns/1ps
module plcb_host (
    input  wire logic        clk_sys_i,
    output logic             cmd_wr_o,
    output logic             cmd_rd_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_wdata_o,
    input  wire logic [15:0] cmd_rdata_i,
    input  wire logic        cmd_rvalid_i,
    input  wire logic        fault_i
);
    initial {cmd_wr_o, cmd_rd_o, cmd_code_o, cmd_wdata_o} = '0;
    // ==========================================
    // Access: strobe for one cycle, answer read half a cycle after the taking edge
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] r, output logic v, output logic f);
        @(negedge clk_sys_i);
        {cmd_wr_o, cmd_rd_o, cmd_code_o, cmd_wdata_o} = {w, !w, c, d};
        @(negedge clk_sys_i);
        {cmd_wr_o, cmd_rd_o} = 2'b00;
        // Released lines never keep the last value
        {cmd_code_o, cmd_wdata_o} = {~c, ~d};
        {r, v, f} = {cmd_rdata_i, cmd_rvalid_i, fault_i};
    endtask
endmodule // plcb_host

/* File: test/pmbus_limit_config_bank_bench.sv */
// Self-checking bench for the limit configuration bank
`timescale 1ns/1ps
module pmbus_limit_config_bank_bench;
    import plcb_pkg::*;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, cmd_wr_i, cmd_rd_i, cmd_rvalid_o, v, f;
    logic comm_memory_fault_o, conv_enable_o, vin_ov_fault_i = 1'b0;
    logic [7:0]  cmd_code_i, page_o;
    logic [15:0] cmd_wdata_i, cmd_rdata_o, sw_freq_o, fault_action_o, r, d;
    logic [15:0] vin_meas_i = 16'h0000;
    logic [1:0]  ov_fault_i = '0, uv_fault_i = '0, oc_fault_i = '0, ot_fault_i = '0;
    logic [1:0]  ut_fault_i = '0, fault_act_valid_o;
    logic [31:0] slew_rate_o, sense_gain_o, seed = 32'h0D0DD839;
    logic [5:0]  fv;
    int miscompares = 0, num_checks = 0, mem [int];
    // Flags nibble: bit 0 paged, bit 1 byte wide; then code and default
    logic [27:0] tbl [23] = '{28'h127AA00, 28'h033FABC, 28'h035CB40, 28'h036CB00,
        28'h138BB9A, 28'h140119A, 28'h34100B8, 28'h1421133, 28'h1430ECD,
        28'h1440E66, 28'h34500B8, 28'h146DBB8, 28'h3470000, 28'h14ADA80,
        28'h14FEB20, 28'h35000B8, 28'h151EAA8, 28'h153E580, 28'h35400B8,
        28'h055E300, 28'h3560080, 28'h058CB26, 28'h05DD280};
    // Input samples with expected enable; mixed exponents compare by value
    logic [16:0] vt [6] = '{17'h0CB3F, 17'h1D1A0, 17'h1CB01, 17'h0CB00, 17'h0CB3F, 17'h1CB40};
    logic [7:0]  pri [6] = '{8'h56, 8'h41, 8'h47, 8'h45, 8'h50, 8'h54};

    plcb_bank #(.NUM_PAGES(2)) i_dut (.clk_sys_i, .arst_n_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i,
        .cmd_wdata_i, .vin_meas_i, .ov_fault_i, .uv_fault_i, .oc_fault_i, .ot_fault_i,
        .ut_fault_i, .vin_ov_fault_i, .cmd_rdata_o, .cmd_rvalid_o, .comm_memory_fault_o,
        .page_o, .conv_enable_o, .slew_rate_o, .sense_gain_o, .sw_freq_o, .fault_action_o,
        .fault_act_valid_o);
    plcb_host i_host (.clk_sys_i, .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i), .cmd_code_o(cmd_code_i),
        .cmd_wdata_o(cmd_wdata_i), .cmd_rdata_i(cmd_rdata_o), .cmd_rvalid_i(cmd_rvalid_o),
        .fault_i(comm_memory_fault_o));

    // ==========================================
    // Clock, watchdog and helpers
    initial forever #10 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        end_sim();
    end
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // Shared entries live under page 0 so every page sees one copy
    function automatic int key(int i, int p);
        return tbl[i][24] ? p * 256 + tbl[i][23:16] : tbl[i][23:16];
    endfunction
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic hacc(input logic w, input logic [7:0] c, input logic [15:0] dd, input logic ef);
        i_host.acc(w, c, dd, r, v, f);
        chk("fault", 16'(f), 16'(ef));
        chk("rvalid", 16'(v), 16'(!w));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        foreach (tbl[i]) for (int p = 0; p < 2; p++) mem[key(i, p)] = tbl[i][15:0];
        for (int p = 0; p < 2; p++) begin
            hacc(1'b1, CMD_PAGE, 16'(p), 1'b0);
            chk("page", 16'(page_o), 16'(p));
            hacc(1'b0, CMD_PAGE, 16'h0000, 1'b0);
            chk("page read", r, 16'(p));
            foreach (tbl[i]) begin
                hacc(1'b0, tbl[i][23:16], 16'h0000, 1'b0);
                chk("default", r, tbl[i][15:0]);
            end
        end
        $display("defaults done");
        foreach (vt[i]) begin
            @(negedge clk_sys_i) vin_meas_i = vt[i][15:0];
            repeat (2) @(negedge clk_sys_i);
            chk("conv", 16'(conv_enable_o), 16'(vt[i][16]));
        end
        $display("conversion done");
        // Page 1 gets all, page 0 every other entry, so shared ones at even index (0x35, 0x5D) are overwritten
        for (int p = 1; p >= 0; p--) begin
            hacc(1'b1, CMD_PAGE, 16'(p), 1'b0);
            foreach (tbl[i]) if (p == 1 || i % 2 == 0) begin
                d = xs();
                hacc(1'b1, tbl[i][23:16], d, 1'b0);
                mem[key(i, p)] = tbl[i][25] ? {8'h00, d[7:0]} : d;
            end
        end
        for (int p = 0; p < 2; p++) begin
            hacc(1'b1, CMD_PAGE, 16'(p), 1'b0);
            foreach (tbl[i]) begin
                hacc(1'b0, tbl[i][23:16], 16'h0000, 1'b0);
                chk("value", r, 16'(mem[key(i, p)]));
            end
            chk("slew", slew_rate_o[p*16+:16], 16'(mem[p*256+8'h27]));
            chk("gain", sense_gain_o[p*16+:16], 16'(mem[p*256+8'h38]));
        end
        chk("freq", sw_freq_o, 16'(mem[8'h33]));
        $display("paging done");
        hacc(1'b0, 8'h01, 16'h0000, 1'b1);
        chk("unknown", r, 16'h0000);
        hacc(1'b1, 8'hD0, 16'h1234, 1'b1);
        hacc(1'b1, CMD_PAGE, 16'h0002, 1'b0);
        hacc(1'b1, CMD_SLEW, 16'h1234, 1'b1);
        hacc(1'b0, CMD_SLEW, 16'h0000, 1'b1);
        chk("beyond", r, 16'h0000);
        hacc(1'b0, CMD_FREQ, 16'h0000, 1'b0);
        chk("shared", r, 16'(mem[8'h33]));
        chk("kept", slew_rate_o[31:16], 16'(mem[256+8'h27]));
        $display("refusal done");
        // Faults from rank i downwards active: rank i must win
        for (int p = 0; p < 2; p++) for (int i = 0; i < 6; i++) begin
            fv = 6'h3F << i;
            @(negedge clk_sys_i);
            {ut_fault_i[p], ot_fault_i[p], uv_fault_i[p], oc_fault_i[p]} = fv[5:2];
            {ov_fault_i[p], vin_ov_fault_i} = fv[1:0];
            repeat (2) @(negedge clk_sys_i);
            chk("action", 16'(fault_action_o[p*8+:8]), 16'(mem[p*256+pri[i]]));
            chk("active", 16'(fault_act_valid_o[p]), 16'h0001);
        end
        {ov_fault_i, uv_fault_i, oc_fault_i, ot_fault_i, ut_fault_i, vin_ov_fault_i} = '0;
        repeat (2) @(negedge clk_sys_i);
        chk("idle", 16'(fault_act_valid_o), 16'h0000);
        $display("faults done");
        end_sim();
    end
endmodule // pmbus_limit_config_bank_bench
